// [design/sfpe_pkg.sv]
// sfpe_pkg: constants shared by the serial flash phase-enable sequencer.
// assumes: included by compile order before design/sfpe_seq.sv and design/sfpe_tgl_sync.sv.
package sfpe_pkg;

	// ----------------------------------------
	// byte slots of one transfer, in bus order
	// ----------------------------------------
	localparam int unsigned SFPE_SLOT_COUNT = 14;
	localparam int unsigned SFPE_BYTE_W     = 8;
	localparam int unsigned SFPE_FRAME_W    = SFPE_SLOT_COUNT * SFPE_BYTE_W;
	localparam logic [3:0]  SFPE_SLOT_CMD   = 4'h0;
	localparam logic [3:0]  SFPE_SLOT_OPTIONAL_COMMAND_BYTE = 4'h1;
	localparam logic [3:0]  SFPE_SLOT_ADR3  = 4'h2;
	localparam logic [3:0]  SFPE_SLOT_OPTION_BYTE_THREE = 4'h6;
	localparam logic [3:0]  SFPE_SLOT_DAT3  = 4'ha;
	localparam logic [3:0]  SFPE_SLOT_LAST  = 4'hd;

	// ----------------------------------------
	// modes, read data enables, last bit index and reset values
	// ----------------------------------------
	localparam logic        SFPE_MODE_READ  = 1'b0;
	localparam logic        SFPE_MODE_SPI   = 1'b1;
	localparam logic [3:0]  SFPE_READ_DATA_EN = 4'hf;
	localparam logic [2:0]  SFPE_BIT_LAST   = 3'h7;
	localparam logic [31:0] SFPE_RDATA_RST  = 32'h0000_0000;

endpackage : sfpe_pkg

// [design/sfpe_tgl_sync.sv]
// sfpe_tgl_sync: carries an event across clocks as a toggle.
// assumes: source toggles at most once per round trip; dst clock is free running.
`timescale 1ns/10ps
`default_nettype none

module sfpe_tgl_sync (
	// destination clock and reset
	input  wire logic clk_i,
	input  wire logic rst_b_i,
	// toggle in, pulse out
	input  wire logic tgl_i,
	output logic      pulse_o
);

	logic meta_r;
	logic sync_r;
	logic last_r;

	// ----------------------------------------
	// two-flop synchroniser then edge detect
	// ----------------------------------------
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			meta_r <= 1'b0;
			sync_r <= 1'b0;
			last_r <= 1'b0;
		end else begin
			meta_r <= tgl_i;
			sync_r <= meta_r;
			last_r <= sync_r;
		end
	end

	assign pulse_o = sync_r ^ last_r;

endmodule // sfpe_tgl_sync

`default_nettype wire

// [design/sfpe_seq.sv]
// sfpe_seq: serial flash transfer sequencer with per-phase and per-byte enables.
// assumes: control ports come from clk_i logic; link_clk_i is the serial bus clock,
// the flash samples io_o and drives io_i on that same clock; single data line.
`timescale 1ns/10ps
`default_nettype none

module sfpe_seq
	import sfpe_pkg::*;
(
	// core clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_b_i,
	// link clock
	input  wire logic        link_clk_i,
	// transfer request
	input  wire logic        start_i,
	input  wire logic        mode_i,
	output logic             busy_o,
	output logic             done_o,
	output logic             cfg_err_o,
	// read-mode enables
	input  wire logic        rm_command_phase_enable_i,
	input  wire logic        rm_optional_command_enable_i,
	input  wire logic [3:0]  rm_address_byte_enables_i,
	input  wire logic [3:0]  rm_option_byte_enables_i,
	// spi-mode enables and control
	input  wire logic        sm_command_phase_enable_i,
	input  wire logic        sm_optional_command_enable_i,
	input  wire logic [3:0]  sm_address_byte_enables_i,
	input  wire logic [3:0]  sm_option_byte_enables_i,
	input  wire logic [3:0]  sm_transfer_byte_enables_i,
	input  wire logic        spi_read_enable_i,
	input  wire logic        spi_write_enable_i,
	// transfer contents
	input  wire logic [7:0]  command_byte_i,
	input  wire logic [7:0]  optional_command_byte_i,
	input  wire logic [31:0] address_i,
	input  wire logic [31:0] option_bytes_i,
	input  wire logic [31:0] wdata_i,
	output logic [31:0]      rdata_o,
	// flash pins
	output logic             cs_b_o,
	output logic             sclk_en_o,
	output logic             io_o,
	output logic             io_oe_o,
	input  wire logic        io_i
);

	typedef enum logic [1:0] {
		SFPE_C_IDLE = 2'b01,
		SFPE_C_BUSY = 2'b10
	} sfpe_cstate_t;

	typedef enum logic [1:0] {
		SFPE_L_IDLE  = 2'b01,
		SFPE_L_SHIFT = 2'b10
	} sfpe_lstate_t;

	// first enabled slot at or after from; valid low when none is left
	function automatic logic [4:0] sfpe_find(input logic [SFPE_SLOT_COUNT-1:0] mask, input logic [4:0] from);
		logic [4:0] res;
		res = 5'h00;
		for (int i = SFPE_SLOT_COUNT - 1; i >= 0; i--) begin
			// slot 0 (command) sits in the top bit of the enable mask
			if (mask[SFPE_SLOT_COUNT - 1 - i] && (i >= int'(from))) begin
				res = {1'b1, 4'(i)};
			end
		end
		return res;
	endfunction

	// ----------------------------------------
	// core domain
	// ----------------------------------------
	sfpe_cstate_t                 cst_r, cst_nxt;
	logic [SFPE_SLOT_COUNT-1:0]   mask_r, mask_nxt;
	logic [SFPE_FRAME_W-1:0]      frame_r, frame_nxt;
	logic                         rx_en_r, rx_en_nxt;
	logic                         tx_en_r, tx_en_nxt;
	logic                         req_tgl_r, req_tgl_nxt;
	logic [31:0]                  rdata_r, rdata_nxt;
	// link-domain shift register, read here only once the ack has crossed
	logic [31:0]                  rx_r, rx_nxt;
	logic                         done_r, done_nxt;
	logic                         err_r, err_nxt;
	logic                         ack_pulse;
	logic [SFPE_SLOT_COUNT-1:0]   req_mask;

	always_comb begin
		if (mode_i == SFPE_MODE_READ) begin
			req_mask = {rm_command_phase_enable_i, rm_optional_command_enable_i,
				rm_address_byte_enables_i, rm_option_byte_enables_i, SFPE_READ_DATA_EN};
		end else begin
			req_mask = {sm_command_phase_enable_i, sm_optional_command_enable_i,
				sm_address_byte_enables_i, sm_option_byte_enables_i, sm_transfer_byte_enables_i};
		end
	end

	always_comb begin
		cst_nxt     = cst_r;
		mask_nxt    = mask_r;
		frame_nxt   = frame_r;
		rx_en_nxt   = rx_en_r;
		tx_en_nxt   = tx_en_r;
		req_tgl_nxt = req_tgl_r;
		rdata_nxt   = rdata_r;
		done_nxt    = 1'b0;
		err_nxt     = 1'b0;
		case (cst_r)
			SFPE_C_IDLE: begin
				if (start_i) begin
					// an all-off spi request would still shift the slot 0 command byte on the link, so it is refused
					if (req_mask == '0) begin
						err_nxt = 1'b1;
					end else begin
						cst_nxt     = SFPE_C_BUSY;
						mask_nxt    = req_mask;
						frame_nxt   = {command_byte_i, optional_command_byte_i,
							address_i, option_bytes_i, wdata_i};
						rx_en_nxt   = (mode_i == SFPE_MODE_READ) ? 1'b1 : spi_read_enable_i;
						tx_en_nxt   = (mode_i == SFPE_MODE_READ) ? 1'b0 : spi_write_enable_i;
						req_tgl_nxt = ~req_tgl_r;
					end
				end
			end
			SFPE_C_BUSY: begin
				if (ack_pulse) begin
					cst_nxt   = SFPE_C_IDLE;
					rdata_nxt = rx_r; // link is idle and rx_r stable here
					done_nxt  = 1'b1;
				end
			end
			default: begin
				cst_nxt = SFPE_C_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			cst_r     <= SFPE_C_IDLE;
			mask_r    <= '0;
			frame_r   <= '0;
			rx_en_r   <= 1'b0;
			tx_en_r   <= 1'b0;
			req_tgl_r <= 1'b0;
			rdata_r   <= SFPE_RDATA_RST;
			done_r    <= 1'b0;
			err_r     <= 1'b0;
		end else begin
			cst_r     <= cst_nxt;
			mask_r    <= mask_nxt;
			frame_r   <= frame_nxt;
			rx_en_r   <= rx_en_nxt;
			tx_en_r   <= tx_en_nxt;
			req_tgl_r <= req_tgl_nxt;
			rdata_r   <= rdata_nxt;
			done_r    <= done_nxt;
			err_r     <= err_nxt;
		end
	end

	assign busy_o    = (cst_r == SFPE_C_BUSY);
	assign done_o    = done_r;
	assign cfg_err_o = err_r;
	assign rdata_o   = rdata_r;

	// ----------------------------------------
	// crossings
	// ----------------------------------------
	// config words stay frozen while busy, so the link reads them after the request edge
	logic ack_tgl_r, ack_tgl_nxt;
	logic req_pulse;

	sfpe_tgl_sync u_req_sync (
		.clk_i   (link_clk_i),
		.rst_b_i (rst_b_i),
		.tgl_i   (req_tgl_r),
		.pulse_o (req_pulse)
	);

	sfpe_tgl_sync u_ack_sync (
		.clk_i   (clk_i),
		.rst_b_i (rst_b_i),
		.tgl_i   (ack_tgl_r),
		.pulse_o (ack_pulse)
	);

	// ----------------------------------------
	// link domain
	// ----------------------------------------
	sfpe_lstate_t lst_r, lst_nxt;
	logic [3:0]   slot_r, slot_nxt;
	logic [2:0]   bit_r, bit_nxt;
	logic         cs_b_r, cs_b_nxt;
	logic         io_r, io_nxt;
	logic         oe_r, oe_nxt;
	logic [4:0]   first_hit;
	logic [4:0]   next_hit;
	logic         in_data;
	logic [7:0]   cur_byte;
	logic [7:0]   first_byte;

	assign first_hit  = sfpe_find(mask_r, 5'h00);
	assign next_hit   = sfpe_find(mask_r, 5'(slot_r) + 5'h01);
	assign in_data    = (slot_r >= SFPE_SLOT_DAT3);
	assign cur_byte   = frame_r[(int'(SFPE_SLOT_LAST) - int'(slot_r)) * SFPE_BYTE_W +: SFPE_BYTE_W];

	always_comb begin
		lst_nxt     = lst_r;
		slot_nxt    = slot_r;
		bit_nxt     = bit_r;
		rx_nxt      = rx_r;
		cs_b_nxt    = cs_b_r;
		io_nxt      = io_r;
		oe_nxt      = oe_r;
		ack_tgl_nxt = ack_tgl_r;
		first_byte  = frame_r[(int'(SFPE_SLOT_LAST) - int'(first_hit[3:0])) * SFPE_BYTE_W +: SFPE_BYTE_W];
		case (lst_r)
			SFPE_L_IDLE: begin
				if (req_pulse) begin
					lst_nxt  = SFPE_L_SHIFT;
					slot_nxt = first_hit[3:0];
					bit_nxt  = SFPE_BIT_LAST;
					cs_b_nxt = 1'b0;
					rx_nxt   = '0;
					io_nxt   = first_byte[SFPE_BIT_LAST];
					oe_nxt   = (first_hit[3:0] < SFPE_SLOT_DAT3) | tx_en_r;
				end
			end
			SFPE_L_SHIFT: begin
				if (in_data && rx_en_r) begin
					rx_nxt = {rx_r[30:0], io_i};
				end
				if (bit_r == 3'h0) begin
					if (next_hit[4]) begin
						slot_nxt = next_hit[3:0];
						bit_nxt  = SFPE_BIT_LAST;
						io_nxt   = frame_r[(int'(SFPE_SLOT_LAST) - int'(next_hit[3:0])) * SFPE_BYTE_W
							+ int'(SFPE_BIT_LAST)];
						oe_nxt   = (next_hit[3:0] < SFPE_SLOT_DAT3) | tx_en_r;
					end else begin
						lst_nxt     = SFPE_L_IDLE;
						cs_b_nxt    = 1'b1;
						oe_nxt      = 1'b0;
						io_nxt      = 1'b0;
						ack_tgl_nxt = ~ack_tgl_r;
					end
				end else begin
					bit_nxt = bit_r - 3'h1;
					io_nxt  = cur_byte[bit_r - 3'h1]; // msb first
				end
			end
			default: begin
				lst_nxt = SFPE_L_IDLE;
			end
		endcase
	end

	always_ff @(posedge link_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			lst_r     <= SFPE_L_IDLE;
			slot_r    <= SFPE_SLOT_CMD;
			bit_r     <= SFPE_BIT_LAST;
			rx_r      <= SFPE_RDATA_RST;
			cs_b_r    <= 1'b1;
			io_r      <= 1'b0;
			oe_r      <= 1'b0;
			ack_tgl_r <= 1'b0;
		end else begin
			lst_r     <= lst_nxt;
			slot_r    <= slot_nxt;
			bit_r     <= bit_nxt;
			rx_r      <= rx_nxt;
			cs_b_r    <= cs_b_nxt;
			io_r      <= io_nxt;
			oe_r      <= oe_nxt;
			ack_tgl_r <= ack_tgl_nxt;
		end
	end

	assign cs_b_o    = cs_b_r;
	assign sclk_en_o = ~cs_b_r;
	assign io_o      = io_r;
	assign io_oe_o   = oe_r;

endmodule // sfpe_seq

`default_nettype wire

// [verif/sfpe_seq_properties.sv]
// sfpe_seq_chk: port timing checks for the sequencer, bound to sfpe_seq.
// assumes: both clocks free running; reset releases both domains.
`timescale 1ns/10ps
`default_nettype none
module sfpe_seq_chk
	import sfpe_pkg::*;
(
	// clocks and reset
	input wire logic        clk_i,
	input wire logic        rst_b_i,
	input wire logic        link_clk_i,
	// core handshake
	input wire logic        start_i,
	input wire logic        mode_i,
	input wire logic        busy_o,
	input wire logic        done_o,
	input wire logic        cfg_err_o,
	input wire logic [31:0] rdata_o,
	// flash pins
	input wire logic        cs_b_o,
	input wire logic        sclk_en_o,
	input wire logic        io_oe_o
);
	// ----------------------------------------
	// core side
	// ----------------------------------------
	sequence accept_s;
		start_i && !busy_o;
	endsequence
	read_start_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		accept_s ##0 mode_i == SFPE_MODE_READ |=> busy_o && !cfg_err_o) else $error("read start refused");
	err_mode_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		cfg_err_o |-> $past(mode_i) == SFPE_MODE_SPI && !busy_o) else $error("bad refusal");
	done_pulse_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		done_o |=> !done_o) else $error("done longer than one cycle");
	done_busy_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		done_o |-> !busy_o && $past(busy_o)) else $error("done without busy end");
	rdata_hold_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		!done_o |-> $stable(rdata_o)) else $error("read data moved without done");
	busy_bound_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		$rose(busy_o) |-> ##[1:300] done_o) else $error("transfer never finished");
	// ----------------------------------------
	// link side
	// ----------------------------------------
	sclk_gate_a: assert property (@(posedge link_clk_i) disable iff (!rst_b_i)
		sclk_en_o != cs_b_o) else $error("clock gate not tied to select");
	idle_drive_a: assert property (@(posedge link_clk_i) disable iff (!rst_b_i)
		cs_b_o |-> !io_oe_o) else $error("data driven while idle");
	byte_min_a: assert property (@(posedge link_clk_i) disable iff (!rst_b_i)
		$fell(cs_b_o) |-> !cs_b_o [*8]) else $error("frame shorter than a byte");
	oe_byte_a: assert property (@(posedge link_clk_i) disable iff (!rst_b_i)
		$rose(io_oe_o) |-> io_oe_o [*8]) else $error("driven byte cut short");
	// bits of the open frame, modulo one byte
	logic [2:0] fbit_r;
	always_ff @(posedge link_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			fbit_r <= 3'h0;
		end else begin
			fbit_r <= cs_b_o ? 3'h0 : fbit_r + 3'h1;
		end
	end
	frame_bytes_a: assert property (@(posedge link_clk_i) disable iff (!rst_b_i)
		$rose(cs_b_o) |-> fbit_r == 3'h0) else $error("frame not made of whole bytes");
endmodule // sfpe_seq_chk
bind sfpe_seq sfpe_seq_chk chk_u (.clk_i, .rst_b_i, .link_clk_i, .start_i, .mode_i, .busy_o,
	.done_o, .cfg_err_o, .rdata_o, .cs_b_o, .sclk_en_o, .io_oe_o);
`default_nettype wire

// [verif/sfpe_flash_model.sv]
// sfpe_flash_model: flash on one data line; counts frame and driven bits.
// assumes: bench resolves the line from the sequencer's output enable.
`timescale 1ns/10ps
`default_nettype none
module sfpe_flash_model (
	// flash pins
	input  wire logic  link_clk_i,
	input  wire logic  cs_b_i,
	input  wire logic  io_oe_i,
	input  wire logic  io_i,
	output logic       io_o,
	// observed frame
	output logic [7:0]  frame_bits_o,
	output logic [7:0]  tx_bits_o,
	output logic [63:0] tx_shift_o
);
	logic new_r;
	initial begin
		io_o = 1'b0;
		new_r = 1'b1;
	end
	// ----------------------------------------
	// sampling and answer
	// ----------------------------------------
	always @(posedge link_clk_i) begin
		if (cs_b_i) begin
			new_r <= 1'b1;
			io_o <= ~io_o; // deselected line keeps changing
		end else begin
			new_r <= 1'b0;
			// answer is the lsb of the bit count: every received byte reads 8'h55
			io_o <= new_r | ~frame_bits_o[0];
			frame_bits_o <= new_r ? 8'h01 : frame_bits_o + 8'h01;
			tx_bits_o <= (new_r ? 8'h00 : tx_bits_o) + {7'h00, io_oe_i};
			if (io_oe_i)
				tx_shift_o <= {tx_shift_o[62:0], io_i};
		end
	end
endmodule // sfpe_flash_model
`default_nettype wire

// [verif/tb_serial_flash_phase_enable.sv]
// tb_serial_flash_phase_enable: directed transfers against a flash model.
// assumes: design and checker compiled first.
`timescale 1ns/10ps
`default_nettype none
module tb_serial_flash_phase_enable;
	import sfpe_pkg::*;
	logic        clk_i, rst_b_i, link_clk_i, start_i, mode_i, busy_o, done_o, cfg_err_o;
	logic        rm_command_phase_enable_i, rm_optional_command_enable_i, sm_command_phase_enable_i;
	logic        sm_optional_command_enable_i, spi_read_enable_i, spi_write_enable_i;
	logic [3:0]  rm_address_byte_enables_i, rm_option_byte_enables_i, sm_address_byte_enables_i;
	logic [3:0]  sm_option_byte_enables_i, sm_transfer_byte_enables_i;
	logic [7:0]  command_byte_i, optional_command_byte_i, fl_frame, fl_tx;
	logic [31:0] address_i, option_bytes_i, wdata_i, rdata_o;
	logic        cs_b_o, sclk_en_o, io_o, io_oe_o, io_i, fl_io;
	logic [63:0] fl_shift;
	int          fails, tests_run, cyc;
	assign io_i = io_oe_o ? io_o : fl_io;
	sfpe_seq dut_u (.clk_i, .rst_b_i, .link_clk_i, .start_i, .mode_i, .busy_o, .done_o, .cfg_err_o,
		.rm_command_phase_enable_i, .rm_optional_command_enable_i, .rm_address_byte_enables_i,
		.rm_option_byte_enables_i, .sm_command_phase_enable_i, .sm_optional_command_enable_i,
		.sm_address_byte_enables_i, .sm_option_byte_enables_i, .sm_transfer_byte_enables_i,
		.spi_read_enable_i, .spi_write_enable_i, .command_byte_i, .optional_command_byte_i,
		.address_i, .option_bytes_i, .wdata_i, .rdata_o, .cs_b_o, .sclk_en_o, .io_o, .io_oe_o, .io_i);
	sfpe_flash_model fl_u (.link_clk_i, .cs_b_i(cs_b_o), .io_oe_i(io_oe_o), .io_i, .io_o(fl_io),
		.frame_bits_o(fl_frame), .tx_bits_o(fl_tx), .tx_shift_o(fl_shift));
	// ----------------------------------------
	// clocks, timeout, tasks
	// ----------------------------------------
	initial begin
		clk_i = 1'b0;
		forever #2 clk_i = ~clk_i;
	end
	initial begin
		link_clk_i = 1'b0;
		#1.3;
		forever #3 link_clk_i = ~link_clk_i;
	end
	always @(posedge clk_i) begin
		cyc++;
		if (cyc == 5000) begin
			fails++;
			give_verdict();
		end
	end
	task automatic give_verdict();
		$display("checks %0d errors %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic check(input string what, input logic [63:0] exp, input logic [63:0] got);
		tests_run++;
		if (exp !== got) begin
			fails++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask
	// start, wait for done, compare what the flash saw
	task automatic xfer(input logic [7:0] frame, input logic [7:0] tx, input logic [63:0] shift);
		logic [63:0] mask;
		int n;
		mask = (64'h0000_0000_0000_0001 << tx) - 64'h0000_0000_0000_0001;
		start_i <= 1'b1;
		@(posedge clk_i);
		start_i <= 1'b0;
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (done_o !== 1'b1 && n < 400);
		check("done", 1'b1, done_o);
		check("frame bits", frame, fl_frame);
		check("driven bits", tx, fl_tx);
		check("driven data", shift & mask, fl_shift & mask);
	endtask
	// ----------------------------------------
	// sequence
	// ----------------------------------------
	initial begin
		{rst_b_i, start_i, mode_i, spi_read_enable_i, spi_write_enable_i} = 5'h00;
		{rm_command_phase_enable_i, rm_optional_command_enable_i, rm_address_byte_enables_i} = 6'h00;
		{sm_command_phase_enable_i, sm_optional_command_enable_i, sm_address_byte_enables_i} = 6'h00;
		{rm_option_byte_enables_i, sm_option_byte_enables_i, sm_transfer_byte_enables_i} = 12'h000;
		{command_byte_i, optional_command_byte_i} = 16'h6b35;
		{address_i, option_bytes_i, wdata_i} = {32'h0012_3456, 32'hc300_0000, 32'ha55a_0ff0};
		repeat (4) @(posedge clk_i);
		rst_b_i <= 1'b1;
		repeat (3) @(posedge clk_i);
		check("idle pins", 5'h10, {cs_b_o, sclk_en_o, io_o, io_oe_o, busy_o});
		check("reset data", SFPE_RDATA_RST, rdata_o);
		mode_i <= SFPE_MODE_SPI;
		sm_command_phase_enable_i <= 1'b1;
		sm_transfer_byte_enables_i <= 4'h3;
		spi_read_enable_i <= 1'b1;
		xfer(8'h18, 8'h08, 64'h0000_0000_0000_006b);
		check("spi read data", 32'h0000_5555, rdata_o);
		sm_command_phase_enable_i <= 1'b0;
		sm_address_byte_enables_i <= 4'hf;
		sm_transfer_byte_enables_i <= 4'hc;
		{spi_read_enable_i, spi_write_enable_i} <= 2'h1;
		xfer(8'h30, 8'h30, 64'h0000_0012_3456_a55a);
		check("write only data", 32'h0000_0000, rdata_o);
		mode_i <= SFPE_MODE_READ;
		rm_command_phase_enable_i <= 1'b1;
		xfer(8'h28, 8'h08, 64'h0000_0000_0000_006b);
		check("read cmd data", 32'h5555_5555, rdata_o);
		rm_optional_command_enable_i <= 1'b1;
		rm_address_byte_enables_i <= 4'h7;
		rm_option_byte_enables_i <= 4'h8;
		xfer(8'h50, 8'h30, 64'h0000_6b35_1234_56c3);
		check("read data", 32'h5555_5555, rdata_o);
		// every spi phase and byte enable off: must be refused, not hang
		mode_i <= SFPE_MODE_SPI;
		{sm_address_byte_enables_i, sm_transfer_byte_enables_i} <= 8'h00;
		start_i <= 1'b1;
		@(posedge clk_i);
		start_i <= 1'b0;
		@(posedge clk_i);
		check("refusal", 2'h2, {cfg_err_o, busy_o});
		give_verdict();
	end
endmodule // tb_serial_flash_phase_enable
`default_nettype wire
